// File: fwsr_pkg.sv
package fwsr_pkg;
	// ======================================================================
	// Register map of the controller (software side)
	// ======================================================================
	localparam logic [3:0] ADDR_CTRL   = 4'h0;
	localparam logic [3:0] ADDR_STATUS = 4'h1;
	localparam logic [3:0] ADDR_ADDR   = 4'h2;
	localparam logic [3:0] ADDR_DATA   = 4'h3;
	localparam logic [3:0] ADDR_RDDATA = 4'h4;

	// CTRL bit positions (write: one-cycle commands, except SINGLE, which is held as a setting)
	localparam int CTRL_START_POS   = 0;
	localparam int CTRL_RESET_POS   = 1;
	localparam int CTRL_ABANDON_POS = 2;
	localparam int CTRL_WINDOW_POS  = 3;
	localparam int CTRL_SINGLE_POS  = 4;

	// STATUS bit positions
	localparam int ST_BUSY_POS   = 0;
	localparam int ST_DONE_POS   = 1;
	localparam int ST_FAIL_POS   = 2;
	localparam int ST_WINDOW_POS = 3;
	localparam int ST_RDY_POS    = 4;
	localparam int ST_SECT_POS   = 5;

	// Flash data bit positions of the status bits
	localparam int POLL_POS   = 7;
	localparam int TOGGLE_POS = 6;
	localparam int FAIL_POS   = 5;
	localparam int WINDOW_POS = 3;
	localparam int SECT_POS   = 2;

	// Reset command written to the device
	localparam logic [15:0] CMD_RESET = 16'h00F0;

	// ======================================================================
	// Pin timing
	// ======================================================================
	localparam int CLK_PERIOD_NS = 20;
	localparam int RD_PULSE_NS   = 100;
	localparam int RD_GAP_NS     = 40;
	localparam int WR_PULSE_NS   = 60;
	localparam int RD_PULSE_CYC  =
		(RD_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int RD_GAP_CYC    =
		(RD_GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int WR_PULSE_CYC  =
		(WR_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam logic [3:0] RST_STATUS = 4'h0;
endpackage : fwsr_pkg

// File: fwsr_cyc_if.sv
interface fwsr_cyc_if;
	logic        rd_req;
	logic        wr_req;
	logic [20:0] addr;
	logic [15:0] wdata;
	logic        done;
	logic [15:0] rdata;

	modport ctl (output rd_req, output wr_req, output addr, output wdata,
		input done, input rdata);
	modport eng (input rd_req, input wr_req, input addr, input wdata,
		output done, output rdata);
endinterface : fwsr_cyc_if

// File: fwsr_cycle.sv
module fwsr_cycle (
	input  wire logic   i_clk,
	input  wire logic   i_resetn,
	fwsr_cyc_if.eng     cyc,
	output logic        o_ce_n,
	output logic        o_oe_n,
	output logic        o_we_n,
	output logic [20:0] o_addr,
	output logic [15:0] o_dq_out,
	output logic        o_dq_oe,
	input  wire logic [15:0] i_dq
);
	// ======================================================================
	// Bus cycle engine: one read or write cycle per request
	// ======================================================================
	typedef enum logic [1:0] {IDLE, RD, WR, GAP} fwsr_cyc_type;
	fwsr_cyc_type st_r;
	logic [3:0]   cnt_r;
	logic [15:0]  rdata_r;
	logic         done_r;

	wire logic last = (cnt_r == 4'h0);

	assign cyc.done  = done_r;
	assign cyc.rdata = rdata_r;

	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			st_r <= IDLE;
			cnt_r <= 4'h0;
			rdata_r <= 16'h0000;
			done_r <= 1'b0;
			o_ce_n <= 1'b1;
			o_oe_n <= 1'b1;
			o_we_n <= 1'b1;
			o_addr <= 21'h000000;
			o_dq_out <= 16'h0000;
			o_dq_oe <= 1'b0;
		end else begin
			done_r <= 1'b0;
			unique case (st_r)
			// A request still standing beside done is the one just served
			IDLE: if (cyc.rd_req && !done_r) begin
				// Both strobes frame the read; the device counts it only while both are low
				st_r <= RD;
				cnt_r <= 4'(fwsr_pkg::RD_PULSE_CYC - 1);
				o_addr <= cyc.addr;
				o_ce_n <= 1'b0;
				o_oe_n <= 1'b0;
			end else if (cyc.wr_req && !done_r) begin
				st_r <= WR;
				cnt_r <= 4'(fwsr_pkg::WR_PULSE_CYC - 1);
				o_addr <= cyc.addr;
				o_dq_out <= cyc.wdata;
				o_dq_oe <= 1'b1;
				o_ce_n <= 1'b0;
				o_we_n <= 1'b0;
			end
			RD: if (last) begin
				rdata_r <= i_dq;
				o_ce_n <= 1'b1;
				o_oe_n <= 1'b1;
				st_r <= GAP;
				cnt_r <= 4'(fwsr_pkg::RD_GAP_CYC - 1);
			end else begin
				cnt_r <= cnt_r - 4'h1;
			end
			WR: if (last) begin
				o_ce_n <= 1'b1;
				o_we_n <= 1'b1;
				st_r <= GAP;
				cnt_r <= 4'(fwsr_pkg::RD_GAP_CYC - 1);
			end else begin
				cnt_r <= cnt_r - 4'h1;
			end
			GAP: if (last) begin
				// Strobe high long enough that the read or write cycle completes
				o_dq_oe <= 1'b0;
				done_r <= 1'b1;
				st_r <= IDLE;
			end else begin
				cnt_r <= cnt_r - 4'h1;
			end
			endcase
		end
	end
endmodule : fwsr_cycle

// File: fwsr_regs.sv
module fwsr_regs (
	input  wire logic        i_clk,
	input  wire logic        i_resetn,
	input  wire logic [3:0]  i_addr,
	input  wire logic        i_rd,
	input  wire logic [31:0] i_status_word,
	input  wire logic [31:0] i_addr_word,
	input  wire logic [31:0] i_data_word,
	input  wire logic [31:0] i_rddata_word,
	output logic      [31:0] o_rdata
);
	// ======================================================================
	// Read mux; data stands in the cycle after the strobe only
	// ======================================================================
	function automatic logic [31:0] pick(input logic [3:0] a,
		input logic [31:0] s, input logic [31:0] ad,
		input logic [31:0] d, input logic [31:0] r);
		unique case (a)
		fwsr_pkg::ADDR_STATUS: pick = s;
		fwsr_pkg::ADDR_ADDR:   pick = ad;
		fwsr_pkg::ADDR_DATA:   pick = d;
		fwsr_pkg::ADDR_RDDATA: pick = r;
		default:               pick = 32'h00000000;
		endcase
	endfunction : pick

	wire logic [31:0] sel = pick(i_addr, i_status_word, i_addr_word,
		i_data_word, i_rddata_word);

	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			o_rdata <= 32'h00000000;
		end else begin
			o_rdata <= i_rd ? sel : 32'h00000000;
		end
	end
endmodule : fwsr_regs

// File: fwsr_host.sv
// Design decisions made here: the address-and-strobe port and the address map.
module fwsr_host (
	input  wire logic        i_clk,
	input  wire logic        i_resetn,
	input  wire logic [3:0]  i_reg_addr,
	input  wire logic [31:0] i_reg_wdata,
	input  wire logic        i_reg_wr,
	input  wire logic        i_reg_rd,
	output logic      [31:0] o_reg_rdata,
	output logic             o_ce_n,
	output logic             o_oe_n,
	output logic             o_we_n,
	output logic      [20:0] o_addr,
	output logic      [15:0] o_dq_out,
	output logic             o_dq_oe,
	input  wire logic [15:0] i_dq,
	input  wire logic        i_ready_busy_in
);
	// ======================================================================
	// Polling state machine
	// ======================================================================
	typedef enum logic [2:0] {
		S_IDLE, S_RD1, S_RD2, S_RECHK, S_RESET, S_WIN
	} fwsr_st_type;

	fwsr_st_type st_r;
	logic [20:0] addr_r;
	logic [15:0] first_r;
	logic [15:0] last_r;
	logic        busy_r;
	logic        done_r;
	logic        fail_r;
	logic        window_r;
	logic        sect_r;
	logic        single_r;
	logic        rdy_r;
	logic        rdy_s_r;

	fwsr_cyc_if cyc ();

	fwsr_cycle u_cycle (
		.i_clk    (i_clk),
		.i_resetn (i_resetn),
		.cyc      (cyc),
		.o_ce_n   (o_ce_n),
		.o_oe_n   (o_oe_n),
		.o_we_n   (o_we_n),
		.o_addr   (o_addr),
		.o_dq_out (o_dq_out),
		.o_dq_oe  (o_dq_oe),
		.i_dq     (i_dq)
	);

	// ======================================================================
	// Software port decode
	// ======================================================================
	wire logic ctrl_wr  = i_reg_wr && (i_reg_addr == fwsr_pkg::ADDR_CTRL);
	wire logic addr_wr  = i_reg_wr && (i_reg_addr == fwsr_pkg::ADDR_ADDR);
	wire logic cmd_start   = ctrl_wr && i_reg_wdata[fwsr_pkg::CTRL_START_POS];
	wire logic cmd_reset   = ctrl_wr && i_reg_wdata[fwsr_pkg::CTRL_RESET_POS];
	wire logic cmd_abandon =
		ctrl_wr && i_reg_wdata[fwsr_pkg::CTRL_ABANDON_POS];
	wire logic cmd_window  =
		ctrl_wr && i_reg_wdata[fwsr_pkg::CTRL_WINDOW_POS];

	// ======================================================================
	// Toggle comparisons
	// ======================================================================
	wire logic cdone = cyc.done;
	wire logic [15:0] rd = cyc.rdata;
	// Status words differ in toggle bit: still running
	wire logic tog_moves = (rd[fwsr_pkg::TOGGLE_POS] !=
		last_r[fwsr_pkg::TOGGLE_POS]);
	wire logic sect_moves = (rd[fwsr_pkg::SECT_POS] !=
		last_r[fwsr_pkg::SECT_POS]);
	wire logic fail_seen = rd[fwsr_pkg::FAIL_POS];

	assign cyc.rd_req = (st_r == S_RD1) || (st_r == S_RD2) ||
		(st_r == S_RECHK) || (st_r == S_WIN);
	assign cyc.wr_req = (st_r == S_RESET);
	// Status reads use the operation's own address, busy bank included
	assign cyc.addr   = addr_r;
	assign cyc.wdata  = fwsr_pkg::CMD_RESET;

	// ======================================================================
	// Sequencer
	// ======================================================================
	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			st_r <= S_IDLE;
			addr_r <= 21'h000000;
			first_r <= 16'h0000;
			last_r <= 16'h0000;
			busy_r <= 1'b0;
			done_r <= 1'b0;
			fail_r <= 1'b0;
			window_r <= 1'b0;
			sect_r <= 1'b0;
			single_r <= 1'b0;
		end else begin
			if (addr_wr)
				addr_r <= i_reg_wdata[20:0];
			if (ctrl_wr)
				single_r <= i_reg_wdata[fwsr_pkg::CTRL_SINGLE_POS];
			unique case (st_r)
			S_IDLE: begin
				if (cmd_reset) begin
					// Software-initiated reset command write
					st_r <= S_RESET;
					busy_r <= 1'b1;
				end else if (cmd_start) begin
					// Always restart from the first double read
					st_r <= S_RD1;
					busy_r <= 1'b1;
					done_r <= 1'b0;
					fail_r <= 1'b0;
				end else if (cmd_window) begin
					st_r <= S_WIN;
					busy_r <= 1'b1;
				end
			end
			S_RD1: if (cdone) begin
				last_r <= rd;
				first_r <= rd;
				st_r <= S_RD2;
			end
			S_RD2: if (cdone) begin
				last_r <= rd;
				sect_r <= sect_moves;
				window_r <= rd[fwsr_pkg::WINDOW_POS];
				if (!tog_moves) begin
					// Toggle steady: operation over, array readable next
					st_r <= S_IDLE;
					busy_r <= 1'b0;
					done_r <= 1'b1;
				end else if (fail_seen) begin
					st_r <= S_RECHK;
				end else if (single_r) begin
					// Software chose to leave; it must restart later
					st_r <= S_IDLE;
					busy_r <= 1'b0;
				end else begin
					st_r <= S_RD2;
				end
			end
			S_RECHK: if (cdone) begin
				last_r <= rd;
				if (!tog_moves) begin
					// Toggle stopped just as the failure bit rose
					st_r <= S_IDLE;
					busy_r <= 1'b0;
					done_r <= 1'b1;
				end else begin
					st_r <= S_RESET;
					fail_r <= 1'b1;
				end
			end
			S_RESET: if (cdone) begin
				st_r <= S_IDLE;
				busy_r <= 1'b0;
			end
			S_WIN: if (cdone) begin
				window_r <= rd[fwsr_pkg::WINDOW_POS];
				last_r <= rd;
				st_r <= S_IDLE;
				busy_r <= 1'b0;
			end
			default: st_r <= S_IDLE;
			endcase
			if (cmd_abandon && st_r != S_RESET && st_r != S_IDLE) begin
				st_r <= S_IDLE;
				busy_r <= 1'b0;
			end
		end
	end

	// Ready pin is a plain level input, two-stage for clean sampling
	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			rdy_s_r <= 1'b1;
			rdy_r <= 1'b1;
		end else begin
			rdy_s_r <= i_ready_busy_in;
			rdy_r <= rdy_s_r;
		end
	end

	wire logic [31:0] status_word = {26'h0, sect_r, rdy_r, window_r,
		fail_r, done_r, busy_r};

	fwsr_regs u_regs (
		.i_clk         (i_clk),
		.i_resetn      (i_resetn),
		.i_addr        (i_reg_addr),
		.i_rd          (i_reg_rd),
		.i_status_word (status_word),
		.i_addr_word   ({11'h000, addr_r}),
		.i_data_word   ({16'h0000, first_r}),
		.i_rddata_word ({16'h0000, last_r}),
		.o_rdata       (o_reg_rdata)
	);
endmodule : fwsr_host

// File: fwsr_host_checker.sv
module fwsr_host_checker (
	input wire logic        i_clk,
	input wire logic        i_resetn,
	input wire logic [3:0]  i_reg_addr,
	input wire logic        i_reg_rd,
	input wire logic [31:0] o_reg_rdata,
	input wire logic        o_ce_n,
	input wire logic        o_oe_n,
	input wire logic        o_we_n,
	input wire logic [20:0] o_addr,
	input wire logic [15:0] o_dq_out,
	input wire logic        o_dq_oe
);
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_resetn);
	// ==================================================================
	// Flash pins
	read_frame_a: assert property (!o_oe_n |-> !o_ce_n && o_we_n)
		else $error("read strobe outside chip select");
	read_pulse_a: assert property ($fell(o_oe_n) |->
		!o_oe_n[*5] ##1 o_oe_n[*2])
		else $error("read pulse or gap length wrong");
	write_pulse_a: assert property ($fell(o_we_n) |->
		(!o_we_n && o_dq_oe)[*3] ##1 o_we_n)
		else $error("write pulse length wrong");
	addr_hold_a: assert property (!o_oe_n && !$past(o_oe_n) |->
		$stable(o_addr))
		else $error("address moved inside a read");
	reset_cmd_a: assert property ($fell(o_we_n) |->
		o_dq_out == fwsr_pkg::CMD_RESET)
		else $error("write is not the reset command");
	bus_turn_a: assert property (o_dq_oe |-> o_oe_n)
		else $error("data driven during a read");
	// ==================================================================
	// Register port
	rdata_idle_a: assert property (!$past(i_reg_rd) |->
		o_reg_rdata == 32'h0)
		else $error("read data outside its cycle");
	unmapped_zero_a: assert property ($past(i_reg_rd) &&
		$past(i_reg_addr) > 4'h4 |-> o_reg_rdata == 32'h0)
		else $error("unmapped read not zero");
endmodule : fwsr_host_checker

bind fwsr_host fwsr_host_checker u_chk (.i_clk(i_clk),
	.i_resetn(i_resetn), .i_reg_addr(i_reg_addr), .i_reg_rd(i_reg_rd),
	.o_reg_rdata(o_reg_rdata), .o_ce_n(o_ce_n), .o_oe_n(o_oe_n),
	.o_we_n(o_we_n), .o_addr(o_addr), .o_dq_out(o_dq_out),
	.o_dq_oe(o_dq_oe));

// File: fwsr_flash_model.sv
module fwsr_flash_model (
	input  wire logic        i_ce_n,
	input  wire logic        i_oe_n,
	input  wire logic        i_we_n,
	input  wire logic [20:0] i_addr,
	input  wire logic [15:0] i_dq_out,
	input  wire logic        i_dq_oe,
	output logic      [15:0] o_dq,
	output logic             o_ready_busy
);
	timeunit 1ns;
	timeprecision 1ps;
	int          busy_left  = 0; // Toggle span in reads
	int          n_reads    = 0;
	int          n_cmds     = 0;
	logic        fail_r     = 1'b0;
	logic        window_r   = 1'b0;
	logic        toggle_r   = 1'b0;
	logic        sect_r     = 1'b0;
	logic        suspend_r  = 1'b0; // Erase suspended
	logic [2:0]  busy_bank  = 3'h0;
	logic [8:0]  erase_sect = 9'h0;
	logic [20:0] cmd_addr   = 21'h0;
	logic [15:0] cmd_data   = 16'h0;
	wire         rd_on = !i_ce_n && !i_oe_n;
	wire         hit = busy_left > 0 && i_addr[20:18] == busy_bank;
	initial o_dq = 16'h0;
	// ==================================================================
	// Read cycles
	always @(posedge rd_on) begin
		#1; // Let the address settle before the status is chosen
		o_dq = hit ? {8'h00, suspend_r, toggle_r, fail_r, 1'b0,
			window_r, sect_r, 2'h0} : 16'h5A3C;
	end
	always @(negedge rd_on) begin
		n_reads++;
		o_dq = ~o_dq; // Released bus must not keep the last value
		if (hit) begin
			if (!suspend_r)
				toggle_r = ~toggle_r;
			if (i_addr[20:12] == erase_sect)
				sect_r = ~sect_r;
			if (!fail_r && !suspend_r)
				busy_left--; // A failed run toggles until reset
		end
	end
	// ==================================================================
	// Write cycles, sampled 10 ns into the pulse to avoid the edge race
	always @(negedge i_we_n) begin
		#10;
		if (!i_ce_n && i_dq_oe) begin
			n_cmds++;
			cmd_addr = i_addr;
			cmd_data = i_dq_out;
			if (i_dq_out == fwsr_pkg::CMD_RESET) begin
				busy_left = 0;
				fail_r = 1'b0;
			end
		end
	end
	assign o_ready_busy = (busy_left > 0 && !suspend_r) ? 1'b0 :
		1'b1;
endmodule : fwsr_flash_model

// File: tb_fwsr_host.sv
`define CHECK(g, e) begin cmp_count++; if ((g) !== (e)) begin n_fail++; \
	$display("wrong value at %0t: %h vs %h", $time, (g), (e)); end end
module tb_fwsr_host;
	timeunit 1ns;
	timeprecision 1ps;
	logic        i_clk = 1'b0;
	logic        i_resetn = 1'b0;
	logic [3:0]  ra = 4'h0;
	logic [31:0] wd = 32'h0;
	logic        wr = 1'b0;
	logic        rd = 1'b0;
	logic [31:0] rdata;
	logic [31:0] st;
	logic        ce_n, oe_n, we_n, dq_oe, rb;
	logic [20:0] fa;
	logic [20:0] a;
	logic        t0;
	logic [15:0] dq_o, dq_i;
	int          n_fail = 0;
	int          cmp_count = 0;
	int          seed = 32'h859042D8;
	int          n;
	initial forever #10 i_clk = ~i_clk;
	fwsr_host DUT (.i_clk(i_clk), .i_resetn(i_resetn), .i_reg_addr(ra),
		.i_reg_wdata(wd), .i_reg_wr(wr), .i_reg_rd(rd),
		.o_reg_rdata(rdata), .o_ce_n(ce_n), .o_oe_n(oe_n), .o_we_n(we_n),
		.o_addr(fa), .o_dq_out(dq_o), .o_dq_oe(dq_oe), .i_dq(dq_i),
		.i_ready_busy_in(rb));
	fwsr_flash_model mdl (.i_ce_n(ce_n), .i_oe_n(oe_n), .i_we_n(we_n),
		.i_addr(fa), .i_dq_out(dq_o), .i_dq_oe(dq_oe), .o_dq(dq_i),
		.o_ready_busy(rb));
	// ==================================================================
	// Register port tasks
	task automatic wr_reg(input logic [3:0] ad, input logic [31:0] d);
		@(posedge i_clk);
		ra <= ad;
		wd <= d;
		wr <= 1'b1;
		@(posedge i_clk);
		wr <= 1'b0;
	endtask : wr_reg
	task automatic rd_reg(input logic [3:0] ad);
		@(posedge i_clk);
		ra <= ad;
		rd <= 1'b1;
		@(posedge i_clk);
		rd <= 1'b0;
		#1 st = rdata;
	endtask : rd_reg
	function automatic int exp_reads(input int nb, input logic t0v);
		// Array bit 6 reads 0: a last toggled 1 costs one more read
		if (nb == 0)
			return 2;
		return (t0v ^ 1'((nb - 1) % 2)) ? nb + 2 : nb + 1;
	endfunction : exp_reads
	task automatic wait_idle();
		int k;
		k = 0;
		rd_reg(fwsr_pkg::ADDR_STATUS);
		while (st[fwsr_pkg::ST_BUSY_POS] !== 1'b0 && k < 300) begin
			rd_reg(fwsr_pkg::ADDR_STATUS);
			k++;
		end
		`CHECK(st[fwsr_pkg::ST_BUSY_POS], 1'b0)
	endtask : wait_idle
	task automatic run_poll(input int nb, input logic f, input int ctl);
		a = 21'($random(seed));
		mdl.busy_bank = a[20:18];
		mdl.erase_sect = a[20:12];
		mdl.busy_left = nb;
		mdl.fail_r = f;
		mdl.n_reads = 0;
		mdl.n_cmds = 0;
		wr_reg(fwsr_pkg::ADDR_ADDR, {11'h0, a});
		wr_reg(fwsr_pkg::ADDR_CTRL, ctl);
		wait_idle();
	endtask : run_poll
	task automatic close_out();
		$display("comparisons %0d, mismatches %0d", cmp_count, n_fail);
		if (n_fail == 0 && cmp_count > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : close_out
	initial begin
		repeat (50000) @(posedge i_clk);
		n_fail++;
		close_out();
	end
	// ==================================================================
	// Scenarios
	initial begin
		repeat (3) @(posedge i_clk);
		i_resetn <= 1'b1;
		repeat (4) @(posedge i_clk);
		rd_reg(fwsr_pkg::ADDR_STATUS);
		`CHECK(st, 32'h1 << fwsr_pkg::ST_RDY_POS)
		rd_reg(4'hF);
		`CHECK(st, 32'h0)
		for (int i = 0; i < 8; i++) begin
			n = (i < 2) ? i : 2 + ($unsigned($random(seed)) % 8);
			t0 = mdl.toggle_r;
			run_poll(n, 1'b0, 1);
			`CHECK(st[fwsr_pkg::ST_DONE_POS], 1'b1)
			`CHECK(mdl.n_reads, exp_reads(n, t0))
			`CHECK(mdl.n_cmds, 0)
		end
		mdl.busy_left = 100000;
		repeat (4) @(posedge i_clk);
		rd_reg(fwsr_pkg::ADDR_STATUS);
		`CHECK(st[fwsr_pkg::ST_RDY_POS], 1'b0)
		run_poll(100000, 1'b1, 1);
		`CHECK(st[fwsr_pkg::ST_FAIL_POS], 1'b1)
		`CHECK(mdl.n_reads >= 3, 1'b1)
		`CHECK(mdl.cmd_data, fwsr_pkg::CMD_RESET)
		`CHECK(mdl.cmd_addr, a)
		run_poll(1000, 1'b0, (1 << fwsr_pkg::CTRL_SINGLE_POS) | 1);
		`CHECK(st[fwsr_pkg::ST_DONE_POS], 1'b0)
		`CHECK(st[fwsr_pkg::ST_SECT_POS], 1'b1)
		mdl.busy_left = 0;
		mdl.n_reads = 0;
		wr_reg(fwsr_pkg::ADDR_CTRL, 32'h1);
		wait_idle();
		`CHECK(st[fwsr_pkg::ST_DONE_POS], 1'b1)
		`CHECK(mdl.n_reads >= 2, 1'b1)
		mdl.suspend_r = 1'b1;
		run_poll(1000, 1'b0, 1);
		`CHECK(st[fwsr_pkg::ST_DONE_POS], 1'b1)
		`CHECK(mdl.n_reads, 2)
		`CHECK(st[fwsr_pkg::ST_SECT_POS], 1'b1)
		`CHECK(st[fwsr_pkg::ST_RDY_POS], 1'b1)
		mdl.suspend_r = 1'b0;
		for (int w = 1; w >= 0; w--) begin
			mdl.window_r = w[0];
			run_poll(50, 1'b0, 1 << fwsr_pkg::CTRL_WINDOW_POS);
			`CHECK(st[fwsr_pkg::ST_WINDOW_POS], w[0])
		end
		close_out();
	end
endmodule : tb_fwsr_host
